// ===== verilog/modem_ctrl_pkg.sv
package modem_ctrl_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [2:0] OFF_MLC  = 3'h0;
   localparam logic [2:0] OFF_IER  = 3'h1;
   localparam logic [2:0] OFF_MSR  = 3'h2;
   localparam logic [2:0] OFF_EVT  = 3'h3;
   localparam logic [2:0] OFF_MASK = 3'h4;

   // ----------------------------------------
   // modem_line_control fields
   // ----------------------------------------
   localparam int MLC_DTR   = 0;
   localparam int MLC_RTS   = 1;
   localparam int MLC_AUX1  = 2;
   localparam int MLC_INTEN = 3;
   localparam int MLC_LOOP  = 4;

   // ----------------------------------------
   // interrupt_enable_register fields
   // ----------------------------------------
   localparam int IER_RX    = 0;
   localparam int IER_TX    = 1;
   localparam int IER_MODEM = 3;

   // ----------------------------------------
   // event status and mask fields
   // ----------------------------------------
   localparam int EVT_RX    = 0;
   localparam int EVT_TX    = 1;
   localparam int EVT_MODEM = 2;

   // ----------------------------------------
   // reset values and writable bits
   // ----------------------------------------
   localparam logic [7:0] MLC_RST  = 8'h00;
   localparam logic [7:0] IER_RST  = 8'h00;
   localparam logic [7:0] EVT_RST  = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] MLC_USED = 8'h1f;
   localparam logic [7:0] IER_USED = 8'h0b;
   localparam logic [7:0] EVT_USED = 8'h07;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   // order matches modem status bits 7:4
   typedef struct packed {
      logic cd;
      logic ri;
      logic dsr;
      logic cts;
   } modem_lines_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

endpackage

// ===== verilog/line_change_detect.sv
`timescale 1ns/10ps

// flags a change of one modem status line
module line_change_detect #(
   parameter bit TRAIL_ONLY = 1'b0
) (
   input  wire logic clk,   // system clock
   input  wire logic rst,   // sync reset, high
   input  wire logic level, // line, active high
   output logic      pulse  // one-cycle change flag
);

   typedef struct packed {
      logic prev;
      logic primed;
   } det_state_t;

   det_state_t r;
   det_state_t next_r;

   always_comb begin
      next_r        = r;
      next_r.prev   = level;
      next_r.primed = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // first cycle after reset only samples, so no false delta
   always_comb begin
      if (TRAIL_ONLY) begin
         pulse = r.primed & r.prev & ~level;
      end else begin
         pulse = r.primed & (r.prev ^ level);
      end
   end

endmodule

// ===== verilog/modem_control_loopback.sv
`timescale 1ns/10ps

module modem_control_loopback (
   input  wire logic       MCLK,    // system clock
   input  wire logic       RST,     // sync reset, high
   input  wire logic [2:0] ADDR,    // register address
   input  wire logic [7:0] WDATA,   // write data
   input  wire logic       WR,      // write strobe
   input  wire logic       RD,      // read strobe
   output logic      [7:0] RDATA,   // read data, cycle after RD
   input  wire logic       TX_DATA, // serial out from transmitter
   output logic            TX,      // serial output pin
   input  wire logic       RX,      // serial input pin
   output logic            RX_DATA, // serial in to receiver
   input  wire logic       CTS_N,   // clear-to-send pin
   input  wire logic       DSR_N,   // data-set-ready pin
   input  wire logic       CD_N,    // carrier detect pin
   input  wire logic       RI_N,    // ring indicator pin
   output logic            RTS_N,   // request-to-send pin
   output logic            DTR_N,   // terminal-ready pin
   output logic            AUX2,    // aux_output_two level
   input  wire logic       RX_EVT,  // receiver interrupt pulse
   input  wire logic       TX_EVT,  // transmitter interrupt pulse
   output logic            INT_O,   // interrupt pin level
   output logic            INT_OE,  // interrupt pin enable
   output logic            IRQ      // level interrupt
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] mlc;
      logic [7:0] interrupt_enable_register;
      logic [3:0] delta;
      logic [7:0] evt;
      logic [7:0] mask;
      logic [7:0] rdata;
      logic       tx_pin;
      logic       rx_data;
      logic       rts_n;
      logic       dtr_n;
      logic       aux2;
      logic       int_o;
      logic       int_oe;
      logic       irq;
   } ctrl_state_t;

   ctrl_state_t r;
   ctrl_state_t next_r;

   // ----------------------------------------
   // host bus request
   // ----------------------------------------
   modem_ctrl_pkg::bus_req_t req;

   assign req.addr  = ADDR;
   assign req.wdata = WDATA;
   assign req.wr    = WR;
   assign req.rd    = RD;

   logic wr_mlc;
   logic wr_ier;
   logic wr_evt;
   logic wr_mask;
   logic rd_msr;

   assign wr_mlc  = req.wr & (req.addr == modem_ctrl_pkg::OFF_MLC);
   assign wr_ier  = req.wr & (req.addr == modem_ctrl_pkg::OFF_IER);
   assign wr_evt  = req.wr & (req.addr == modem_ctrl_pkg::OFF_EVT);
   assign wr_mask = req.wr & (req.addr == modem_ctrl_pkg::OFF_MASK);
   assign rd_msr  = req.rd & (req.addr == modem_ctrl_pkg::OFF_MSR);

   // ----------------------------------------
   // modem status sources
   // ----------------------------------------
   logic loop_on;

   assign loop_on = r.mlc[modem_ctrl_pkg::MLC_LOOP];

   modem_ctrl_pkg::modem_lines_t pin_lines;
   modem_ctrl_pkg::modem_lines_t loop_lines;
   modem_ctrl_pkg::modem_lines_t lines;

   // pins are active low, status bits active high
   assign pin_lines.cts = ~CTS_N;
   assign pin_lines.dsr = ~DSR_N;
   assign pin_lines.cd  = ~CD_N;
   assign pin_lines.ri  = ~RI_N;

   // control bits fold back onto the status inputs
   assign loop_lines.cts = r.mlc[modem_ctrl_pkg::MLC_RTS];
   assign loop_lines.dsr = r.mlc[modem_ctrl_pkg::MLC_DTR];
   assign loop_lines.ri  = r.mlc[modem_ctrl_pkg::MLC_AUX1];
   assign loop_lines.cd  = r.mlc[modem_ctrl_pkg::MLC_INTEN];

   // pins are ignored entirely while looped back
   assign lines = loop_on ? loop_lines : pin_lines;

   // ----------------------------------------
   // change detection
   // ----------------------------------------
   logic [3:0] line_vec;
   logic [3:0] change;

   assign line_vec = lines;

   // bit 2 is ring: only its trailing edge counts
   generate
      for (genvar i = 0; i < 4; i++) begin : g_det
         line_change_detect #(
            .TRAIL_ONLY (i == 2)
         ) u_det (
            .clk   (MCLK),
            .rst   (RST),
            .level (line_vec[i]),
            .pulse (change[i])
         );
      end
   endgenerate

   // ----------------------------------------
   // interrupt sources
   // ----------------------------------------
   logic       rx_src;
   logic       tx_src;
   logic       modem_src;
   logic [7:0] evt_set;

   // same gating in both modes
   assign rx_src    = RX_EVT & r.interrupt_enable_register[modem_ctrl_pkg::IER_RX];
   assign tx_src    = TX_EVT & r.interrupt_enable_register[modem_ctrl_pkg::IER_TX];
   assign modem_src = (|change)
                    & r.interrupt_enable_register[modem_ctrl_pkg::IER_MODEM];

   always_comb begin
      evt_set                           = 8'h00;
      evt_set[modem_ctrl_pkg::EVT_RX]    = rx_src;
      evt_set[modem_ctrl_pkg::EVT_TX]    = tx_src;
      evt_set[modem_ctrl_pkg::EVT_MODEM] = modem_src;
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      case (req.addr)
         modem_ctrl_pkg::OFF_MLC: begin
            rd_mux = r.mlc;
         end
         modem_ctrl_pkg::OFF_IER: begin
            rd_mux = r.interrupt_enable_register;
         end
         modem_ctrl_pkg::OFF_MSR: begin
            rd_mux = {line_vec, r.delta};
         end
         modem_ctrl_pkg::OFF_EVT: begin
            rd_mux = r.evt;
         end
         modem_ctrl_pkg::OFF_MASK: begin
            rd_mux = r.mask;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_r = r;

      // reserved bits (mlc 7:5, ier 7:4 and 2, mask 7:3) are not stored and read zero
      if (wr_mlc) begin
         next_r.mlc = req.wdata & modem_ctrl_pkg::MLC_USED;
      end
      if (wr_ier) begin
         next_r.interrupt_enable_register = req.wdata & modem_ctrl_pkg::IER_USED;
      end
      if (wr_mask) begin
         next_r.mask = req.wdata & modem_ctrl_pkg::EVT_USED;
      end

      // delta bits clear on a status read; a new change wins
      if (rd_msr) begin
         next_r.delta = change;
      end else begin
         next_r.delta = r.delta | change;
      end

      // write one to clear; a set in the same cycle wins
      if (wr_evt) begin
         next_r.evt = (r.evt & ~req.wdata) | evt_set;
      end else begin
         next_r.evt = r.evt | evt_set;
      end

      next_r.irq = |(next_r.evt & next_r.mask);

      // interrupt pin follows the request, enabled by bit 3
      next_r.int_o  = next_r.irq;
      next_r.int_oe = next_r.mlc[modem_ctrl_pkg::MLC_INTEN];
      next_r.aux2   = ~next_r.mlc[modem_ctrl_pkg::MLC_INTEN];

      // RTS_N and DTR_N idle high while looped back
      if (next_r.mlc[modem_ctrl_pkg::MLC_LOOP]) begin
         next_r.rts_n = 1'b1;
         next_r.dtr_n = 1'b1;
      end else begin
         next_r.rts_n = ~next_r.mlc[modem_ctrl_pkg::MLC_RTS];
         next_r.dtr_n = ~next_r.mlc[modem_ctrl_pkg::MLC_DTR];
      end

      // serial path: transmitter feeds receiver in loopback
      if (loop_on) begin
         next_r.tx_pin  = 1'b1;
         next_r.rx_data = TX_DATA;
      end else begin
         next_r.tx_pin  = TX_DATA;
         next_r.rx_data = RX;
      end

      // read data stands one cycle only
      if (req.rd) begin
         next_r.rdata = rd_mux;
      end else begin
         next_r.rdata = 8'h00;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         r         <= '0;
         r.mlc     <= modem_ctrl_pkg::MLC_RST;
         r.interrupt_enable_register     <= modem_ctrl_pkg::IER_RST;
         r.evt     <= modem_ctrl_pkg::EVT_RST;
         r.mask    <= modem_ctrl_pkg::MASK_RST;
         r.tx_pin  <= 1'b1;
         r.rx_data <= 1'b1;
         r.rts_n   <= 1'b1;
         r.dtr_n   <= 1'b1;
         r.aux2    <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign RDATA   = r.rdata;
   assign TX      = r.tx_pin;
   assign RX_DATA = r.rx_data;
   assign RTS_N   = r.rts_n;
   assign DTR_N   = r.dtr_n;
   assign AUX2    = r.aux2;
   assign INT_O   = r.int_o;
   assign INT_OE  = r.int_oe;
   assign IRQ     = r.irq;

endmodule

// ===== dv/modem_control_loopback_properties.sv
`timescale 1ns/10ps

// -------------------------
// port checker
// -------------------------
module modem_control_loopback_properties (
   input wire logic       MCLK,    // clock
   input wire logic       RST,     // reset
   input wire logic [2:0] ADDR,    // address
   input wire logic [7:0] WDATA,   // wdata
   input wire logic       WR,      // write
   input wire logic       RD,      // read
   input wire logic [7:0] RDATA,   // rdata
   input wire logic       TX_DATA, // tx bit
   input wire logic       TX,      // tx pin
   input wire logic       RTS_N,   // rts
   input wire logic       DTR_N,   // dtr
   input wire logic       AUX2,    // aux2
   input wire logic       RX_EVT,  // rx event
   input wire logic       INT_OE,  // int enable
   input wire logic       IRQ      // irq
);
   // shadows built from the bus alone
   logic [4:0] m;
   logic [3:0] i;
   logic [2:0] k;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   always_ff @(posedge MCLK) begin
      if (RST) begin
         m <= 5'h00;
         i <= 4'h0;
         k <= 3'h0;
      end else if (WR) begin
         m <= (ADDR == 3'h0) ? WDATA[4:0] : m;
         i <= (ADDR == 3'h1) ? WDATA[3:0] : i;
         k <= (ADDR == 3'h4) ? WDATA[2:0] : k;
      end
   end

   property p_rts; RTS_N == (m[4] | !m[1]); endproperty
   a_rts: assert property (p_rts) else $error("rts level");
   property p_dtr; DTR_N == (m[4] | !m[0]); endproperty
   a_dtr: assert property (p_dtr) else $error("dtr level");
   property p_off; !m[3] |-> AUX2 && !INT_OE; endproperty
   a_off: assert property (p_off) else $error("int not off");
   property p_on; m[3] |-> !AUX2 && INT_OE; endproperty
   a_on: assert property (p_on) else $error("int not on");
   property p_tx; !$past(RST) && $stable(m) |-> TX == ($past(m[4]) | $past(TX_DATA)); endproperty
   a_tx: assert property (p_tx) else $error("tx pin");
   property p_rd; RD && ADDR == 3'h0 |=> RDATA == {3'h0, $past(m)}; endproperty
   a_rd: assert property (p_rd) else $error("mlc read");
   property p_evt; RX_EVT && i[0] && k[0] && !WR |=> IRQ; endproperty
   a_evt: assert property (p_evt) else $error("rx irq");
   property p_lp; m[4] && i[3] && k[2] && WR && ADDR == 3'h0 && WDATA[4] && WDATA[1] != m[1] |-> ##[1:3] IRQ;
   endproperty
   a_lp: assert property (p_lp) else $error("loop irq");
endmodule

bind modem_control_loopback modem_control_loopback_properties u_chk (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_DATA(TX_DATA), .TX(TX), .RTS_N(RTS_N),
   .DTR_N(DTR_N), .AUX2(AUX2), .RX_EVT(RX_EVT), .INT_OE(INT_OE), .IRQ(IRQ));

// ===== dv/modem_partner.sv
`timescale 1ns/10ps

// -------------------------
// far-side modem
// -------------------------
module modem_partner (
   input  wire logic clk,     // clock
   input  wire logic slow,    // lagged cts
   input  wire logic ring,    // ring on
   input  wire logic carrier, // carrier on
   input  wire logic rts_n,   // rts
   input  wire logic dtr_n,   // dtr
   input  wire logic tx,      // tx
   output logic      cts_n,   // cts
   output logic      dsr_n,   // dsr
   output logic      cd_n,    // cd
   output logic      ri_n,    // ri
   output logic      rx       // tx echo
);
   logic [3:0] lag = 4'hf;

   initial {cts_n, dsr_n, cd_n, ri_n, rx} = 5'h1f;
   // slow answer lags rts by five cycles, four more than the normal answer
   always @(posedge clk) begin
      lag <= {lag[2:0], rts_n};
      cts_n <= slow ? lag[3] : rts_n;
      dsr_n <= dtr_n;
      cd_n <= !carrier;
      ri_n <= !ring;
      rx <= tx;
   end
endmodule

// ===== dv/modem_control_loopback_tb.sv
`timescale 1ns/10ps

module modem_control_loopback_tb;
   logic        MCLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, TX_DATA = 1'b1, RX_EVT = 1'b0, TX_EVT = 1'b0;
   logic [2:0]  ADDR = 3'h0;
   logic [7:0]  WDATA = 8'h00, RDATA, d;
   logic        slow = 1'b0, ring = 1'b0, carrier = 1'b0;
   logic        RX, CTS_N, DSR_N, CD_N, RI_N, TX, RX_DATA, RTS_N, DTR_N, AUX2, INT_O, INT_OE, IRQ;
   logic [31:0] v;
   logic [4:0]  m;
   int          err_total = 0, n_tests = 0, seed = 27853, cyc = 0;

   always #20 MCLK = ~MCLK;

   modem_control_loopback u_dut (.MCLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .TX_DATA, .TX, .RX,
      .RX_DATA, .CTS_N, .DSR_N, .CD_N, .RI_N, .RTS_N, .DTR_N, .AUX2, .RX_EVT, .TX_EVT, .INT_O, .INT_OE, .IRQ);
   modem_partner u_far (.clk(MCLK), .slow, .ring, .carrier, .rts_n(RTS_N), .dtr_n(DTR_N), .tx(TX),
      .cts_n(CTS_N), .dsr_n(DSR_N), .cd_n(CD_N), .ri_n(RI_N), .rx(RX));

   task automatic chk(input logic [7:0] s, e, input string n);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] x);
      @(posedge MCLK);
      {ADDR, WDATA, WR} <= {a, x, 1'b1};
      @(posedge MCLK);
      WR <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge MCLK);
      {ADDR, RD} <= {a, 1'b1};
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      d = RDATA;
   endtask
   task automatic ev(input logic t);
      @(posedge MCLK);
      {RX_EVT, TX_EVT} <= {!t, t};
      @(posedge MCLK);
      {RX_EVT, TX_EVT} <= 2'b00;
      #1;
   endtask
   // status lines come from the low bits in loopback, else from the pins
   function automatic logic [3:0] hi(input logic [4:0] x);
      return x[4] ? {x[3], x[2], x[0], x[1]} : ~{CD_N, RI_N, DSR_N, CTS_N};
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         wrap_up;
      end
   end

   initial begin
      repeat (12) @(posedge MCLK);
      RST <= 1'b0;
      w(1);
      chk({RTS_N, DTR_N, AUX2, INT_OE, TX, IRQ}, 8'h3a, "reset pins");
      for (int a = 0; a < 8; a++) begin
         if (a > 4) wr(a[2:0], 8'hff);
         rd(a[2:0]);
         chk(d, 8'h00, "reg");
      end
      repeat (24) begin
         v = $random(seed);
         m = v[4:0];
         @(posedge MCLK);
         {TX_DATA, ring, carrier, slow} <= v[8:5];
         wr(3'h0, {3'h0, m});
         w(8);
         chk({TX, RX_DATA, RTS_N, DTR_N, AUX2, INT_OE}, {2'b00, m[4] | TX_DATA, m[4] ? TX_DATA : RX,
            m[4] | !m[1], m[4] | !m[0], !m[3], m[3]}, "pins");
         rd(3'h2);
         chk(d[7:4], hi(m), "status");
      end
      for (int lp = 0; lp < 2; lp++) begin
         wr(3'h0, lp ? 8'h10 : 8'h00);
         wr(3'h1, 8'h03);
         wr(3'h4, 8'h01);
         wr(3'h3, 8'h07);
         ev(1'b0);
         chk({IRQ, INT_O}, 8'h03, "rx irq");
         wr(3'h3, 8'h01);
         ev(1'b1);
         chk(IRQ, 8'h00, "masked irq");
         rd(3'h3);
         chk(d, 8'h02, "events");
         wr(3'h4, 8'h03);
         w(1);
         chk(IRQ, 8'h01, "unmasked irq");
         wr(3'h3, 8'h02);
         w(1);
         chk(IRQ, 8'h00, "cleared irq");
         wr(3'h1, 8'h00);
         ev(1'b0);
         rd(3'h3);
         chk(d, 8'h00, "disabled");
      end
      wr(3'h1, 8'h08);
      wr(3'h4, 8'h04);
      rd(3'h2);
      wr(3'h3, 8'h07);
      wr(3'h0, 8'h12);
      w(3);
      chk(IRQ, 8'h01, "modem irq");
      wr(3'h0, 8'h16);
      wr(3'h0, 8'h12);
      w(3);
      rd(3'h2);
      chk(d, 8'h15, "loop status");
      wrap_up;
   end
endmodule
